// *** rtl/dbg_pkg.sv ***
// Shared constants and types for the debug, trace and test port
`default_nettype none
package dbg_pkg;
    // ************************************************
    // Trace values
    // ************************************************
    localparam logic [3:0] PST_HALT = 4'hF;
    localparam logic [3:0] PST_C = 4'hC;
    localparam logic [3:0] PST_D = 4'hD;
    localparam logic [3:0] PST_RST = 4'h0;
    localparam logic [3:0] DDATA_HALT = 4'hF;
    // ************************************************
    // Test port
    // ************************************************
    localparam logic [3:0] IR_CAPT = 4'h1;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    // ************************************************
    // Serial debug link
    // ************************************************
    localparam int PKT_W = 17;
    localparam logic [4:0] PKT_LAST = 5'h10;
    localparam logic [4:0] PKT_CNT_RST = 5'h00;
    localparam int DEV_SERIAL_CLOCK_RATIO = 5;
    // Synchronised pin vector positions
    localparam int P_JEN = 0;
    localparam int P_TCK = 1;
    localparam int P_TMS = 2;
    localparam int P_TDI = 3;
    localparam int P_DSC = 4;
    localparam int P_DSI = 5;
    localparam int P_BKP = 6;
    localparam int PIN_N = 7;
    // ************************************************
    // State machines
    // ************************************************
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
        ST_UP_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UP_IR = 16'h8000
    } tap_state_t;
    typedef enum logic [2:0] {
        BRK_RUN = 3'h1,
        BRK_PEND = 3'h2,
        BRK_HALT = 3'h4
    } brk_state_t;
endpackage : dbg_pkg
`default_nettype wire

// *** rtl/tap_if.sv ***
// Link between the port top and its test state machine
`default_nettype none
interface tap_if
    import dbg_pkg::*;
    ();
    logic tck_rise;
    logic tms;
    tap_state_t state;
    modport ctrl (input tck_rise, input tms, output state);
    modport user (output tck_rise, output tms, input state);
endinterface : tap_if
`default_nettype wire

// *** rtl/tap_fsm.sv ***
// Sixteen-state test access port controller
`default_nettype none
module tap_fsm
    import dbg_pkg::*;
(
    // Clock and combined test reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Controller link
    tap_if.ctrl tap
);
    tap_state_t state_r;
    tap_state_t state_nxt;

    // ************************************************
    // Next state on each test clock rise
    // ************************************************
    always_comb begin
        state_nxt = state_r;
        if (tap.tck_rise) begin
            case (state_r)
                ST_RESET: state_nxt = tap.tms ? ST_RESET : ST_IDLE;
                ST_IDLE: state_nxt = tap.tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: state_nxt = tap.tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: state_nxt = tap.tms ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR: state_nxt = tap.tms ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: state_nxt = tap.tms ? ST_UP_DR : ST_PA_DR;
                ST_PA_DR: state_nxt = tap.tms ? ST_EX2_DR : ST_PA_DR;
                ST_EX2_DR: state_nxt = tap.tms ? ST_UP_DR : ST_SH_DR;
                ST_UP_DR: state_nxt = tap.tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: state_nxt = tap.tms ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR: state_nxt = tap.tms ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR: state_nxt = tap.tms ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: state_nxt = tap.tms ? ST_UP_IR : ST_PA_IR;
                ST_PA_IR: state_nxt = tap.tms ? ST_EX2_IR : ST_PA_IR;
                ST_EX2_IR: state_nxt = tap.tms ? ST_UP_IR : ST_SH_IR;
                ST_UP_IR: state_nxt = tap.tms ? ST_SEL_DR : ST_IDLE;
                default: state_nxt = ST_RESET;
            endcase
        end
    end

    // Test reset acts without any clock edge
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign tap.state = state_r;

    // ************************************************
    // Checks
    // ************************************************
    a_tms_exit_dr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_r == ST_SH_DR && tap.tck_rise && tap.tms) |=> state_r == ST_EX1_DR)
        else $error("shift-DR did not exit on tms high");
    a_tap_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !tap.tck_rise |=> $stable(state_r))
        else $error("test state moved without a test clock rise");
endmodule : tap_fsm
`default_nettype wire

// *** rtl/debug_port.sv ***
// Debug support: test port, serial debug link, breakpoint and trace
//
// Summary of operation
// - Debug-select pin caught at reset picks test port or background debug port.
// - Test reset low initialises test logic at once, no clock needed.
// - Test state machine steps on mode-select sampled at test clock rise.
// - Test data input captured on test clock rise.
// - Test data output driven only in shift-IR and shift-DR, else floating.
// - Test data output changes only at test clock fall.
// - Serial clock level accepted after equal samples on two bus clock rises.
// - Validated serial clock rise samples serial input and steps serial output.
// - Serial output is registered, changes after validated serial clock high.
// - Breakpoint request halts processor after current instruction completes.
// - While halted, status and status/data outputs show all ones.
// - Breakpoint-disable set turns the request into a debug interrupt.
// - Status-clock-disable freezes clock and, once the status clock has started, trace outputs; clearing restarts them.
// - Status clock idle until first status value C, D or F.
// - Status clock rises mid-window of status and debug data outputs.
// - Debug data outputs show captured processor data and breakpoint status.
// - Combined status output is the AND of all four status bits.
// - Status reported synchronously to processor clock, not bus transfers.
`default_nettype none
module debug_port
    import dbg_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Test port pins
    input wire logic jtag_en_i,
    input wire logic trst_n_i,
    input wire logic tclk_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic jtag_mode_o,
    output logic [3:0] test_instr_o,
    // Serial debug link pins
    input wire logic dev_serial_clock_i,
    input wire logic dev_serial_in_i,
    output logic dev_serial_out_o,
    // Packet side towards the debug module
    input wire logic [PKT_W-1:0] pkt_tx_data_i,
    output logic pkt_rx_valid_o,
    output logic [PKT_W-1:0] pkt_rx_data_o,
    // Breakpoint and core
    input wire logic breakpoint_request_i,
    input wire logic breakpoint_disable_i,
    input wire logic instr_done_i,
    input wire logic resume_i,
    input wire logic [3:0] core_status_i,
    input wire logic [3:0] core_data_i,
    output logic halt_o,
    output logic debug_irq_o,
    // Trace pins
    input wire logic status_clock_disable_i,
    output logic [3:0] processor_status_o,
    output logic [3:0] debug_data_o,
    output logic [7:0] status_data_bus_o,
    output logic status_all_ones_o,
    output logic status_clock_o
);
    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] sync1_r;
    logic [PIN_N-1:0] sync2_r;
    assign pin_raw = {breakpoint_request_i, dev_serial_in_i, dev_serial_clock_i,
                      tdi_i, tms_i, tclk_i, jtag_en_i};
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    // ************************************************
    // Strap capture and edge history
    // ************************************************
    logic [1:0] strap_cnt_r, strap_cnt_nxt;
    logic jtag_mode_r, jtag_mode_nxt;
    logic tck_prev_r, ds_prev_r, ds_lvl_r, ds_lvl_nxt, bkp_prev_r;
    logic strap_done;
    assign strap_done = (strap_cnt_r == STRAP_WAIT);
    always_comb begin
        strap_cnt_nxt = strap_done ? strap_cnt_r : strap_cnt_r + 2'h1;
        // Pin waits out the synchroniser, then stays fixed until next reset
        jtag_mode_nxt = (strap_cnt_r == STRAP_WAIT - 2'h1) ? sync2_r[P_JEN] : jtag_mode_r;
        // Accept a level only when two bus clock rises agree
        ds_lvl_nxt = (sync2_r[P_DSC] == ds_prev_r) ? ds_prev_r : ds_lvl_r;
    end
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_cnt_r <= 2'h0;
            jtag_mode_r <= 1'b0;
            tck_prev_r <= 1'b0;
            ds_prev_r <= 1'b0;
            ds_lvl_r <= 1'b0;
            bkp_prev_r <= 1'b0;
        end else begin
            strap_cnt_r <= strap_cnt_nxt;
            jtag_mode_r <= jtag_mode_nxt;
            tck_prev_r <= sync2_r[P_TCK];
            ds_prev_r <= sync2_r[P_DSC];
            ds_lvl_r <= ds_lvl_nxt;
            bkp_prev_r <= sync2_r[P_BKP];
        end
    end
    assign jtag_mode_o = jtag_mode_r;

    // ************************************************
    // Test port datapath
    // ************************************************
    logic tap_rst_n, tck_rise, tck_fall;
    logic [3:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
    logic byp_r, byp_nxt, tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
    tap_if tap ();
    // Pin reset joins system reset; glitches on it reset the test logic
    assign tap_rst_n = arst_n_i & trst_n_i;
    assign tck_rise = jtag_mode_r & strap_done & sync2_r[P_TCK] & ~tck_prev_r;
    assign tck_fall = jtag_mode_r & strap_done & ~sync2_r[P_TCK] & tck_prev_r;
    assign tap.tck_rise = tck_rise;
    assign tap.tms = sync2_r[P_TMS];
    tap_fsm u_tap (
        .mclk_i (mclk_i),
        .rst_n_i (tap_rst_n),
        .tap (tap)
    );
    always_comb begin
        ir_sh_nxt = ir_sh_r;
        ir_nxt = ir_r;
        byp_nxt = byp_r;
        tdo_nxt = tdo_r;
        tdo_oe_nxt = tdo_oe_r;
        if (tck_rise) begin
            case (tap.state)
                ST_RESET: ir_nxt = IR_BYPASS;
                ST_CAP_IR: ir_sh_nxt = IR_CAPT;
                ST_SH_IR: ir_sh_nxt = {sync2_r[P_TDI], ir_sh_r[3:1]};
                ST_UP_IR: ir_nxt = ir_sh_r;
                ST_CAP_DR: byp_nxt = 1'b0;
                ST_SH_DR: byp_nxt = sync2_r[P_TDI];
                default: byp_nxt = byp_r;
            endcase
        end
        if (tck_fall) begin
            tdo_nxt = (tap.state == ST_SH_IR) ? ir_sh_r[0] : byp_r;
            tdo_oe_nxt = (tap.state == ST_SH_IR) || (tap.state == ST_SH_DR);
        end
    end
    always_ff @(posedge mclk_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sh_r <= IR_CAPT;
            ir_r <= IR_BYPASS;
            byp_r <= 1'b0;
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            ir_sh_r <= ir_sh_nxt;
            ir_r <= ir_nxt;
            byp_r <= byp_nxt;
            tdo_r <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end
    assign tdo_o = tdo_r;
    assign tdo_oe_o = tdo_oe_r;
    assign test_instr_o = ir_r;

    // ************************************************
    // Serial debug link
    // ************************************************
    logic ds_rise;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [PKT_W-1:0] rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt;
    logic dso_r, dso_nxt, rx_vld_r, rx_vld_nxt;
    // Link is dead while the shared pins serve the test port
    assign ds_rise = ~jtag_mode_r & strap_done & ds_lvl_nxt & ~ds_lvl_r;
    always_comb begin
        bit_cnt_nxt = bit_cnt_r;
        rx_sh_nxt = rx_sh_r;
        tx_sh_nxt = tx_sh_r;
        dso_nxt = dso_r;
        rx_vld_nxt = 1'b0;
        if (ds_rise) begin
            rx_sh_nxt = {rx_sh_r[PKT_W-2:0], sync2_r[P_DSI]};
            dso_nxt = tx_sh_r[PKT_W-1];
            tx_sh_nxt = {tx_sh_r[PKT_W-2:0], 1'b0};
            if (bit_cnt_r == PKT_LAST) begin
                bit_cnt_nxt = PKT_CNT_RST;
                rx_vld_nxt = 1'b1;
                tx_sh_nxt = pkt_tx_data_i;
            end else begin
                bit_cnt_nxt = bit_cnt_r + 5'h01;
            end
        end
    end
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt_r <= PKT_CNT_RST;
            rx_sh_r <= '0;
            tx_sh_r <= '0;
            dso_r <= 1'b0;
            rx_vld_r <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_sh_r <= tx_sh_nxt;
            dso_r <= dso_nxt;
            rx_vld_r <= rx_vld_nxt;
        end
    end
    assign dev_serial_out_o = dso_r;
    assign pkt_rx_valid_o = rx_vld_r;
    assign pkt_rx_data_o = rx_sh_r;

    // ************************************************
    // Breakpoint handling
    // ************************************************
    brk_state_t brk_r, brk_nxt;
    logic irq_nxt, irq_r;
    always_comb begin
        brk_nxt = brk_r;
        irq_nxt = 1'b0;
        case (brk_r)
            BRK_RUN: if (sync2_r[P_BKP] && !bkp_prev_r) brk_nxt = BRK_PEND;
            BRK_PEND: begin
                if (instr_done_i) begin
                    brk_nxt = breakpoint_disable_i ? BRK_RUN : BRK_HALT;
                    irq_nxt = breakpoint_disable_i;
                end
            end
            BRK_HALT: if (resume_i) brk_nxt = BRK_RUN;
            default: brk_nxt = BRK_RUN;
        endcase
    end
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            brk_r <= BRK_RUN;
            irq_r <= 1'b0;
        end else begin
            brk_r <= brk_nxt;
            irq_r <= irq_nxt;
        end
    end
    assign halt_o = (brk_r == BRK_HALT);
    assign debug_irq_o = irq_r;

    // ************************************************
    // Trace outputs and status clock
    // ************************************************
    logic started_r, started_nxt, phase_r, phase_nxt, load;
    logic [3:0] pst_r, pst_nxt, dd_r, dd_nxt;
    logic all_r, all_nxt;
    always_comb begin
        // Reset exception start is marked by the first C, D or F status
        started_nxt = started_r | (core_status_i == PST_C) | (core_status_i == PST_D)
                      | (core_status_i == PST_HALT) | halt_o;
        // Frozen clock keeps its level; probe must resync after release
        phase_nxt = (started_r && !status_clock_disable_i) ? ~phase_r : phase_r;
        // New value two cycles wide, clock rises one cycle in
        load = !started_r || (phase_r && !status_clock_disable_i);
        pst_nxt = pst_r;
        dd_nxt = dd_r;
        if (load) begin
            pst_nxt = halt_o ? PST_HALT : core_status_i;
            dd_nxt = halt_o ? DDATA_HALT : core_data_i;
        end
        all_nxt = &pst_nxt;
    end
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            started_r <= 1'b0;
            phase_r <= 1'b0;
            pst_r <= PST_RST;
            dd_r <= PST_RST;
            all_r <= 1'b0;
        end else begin
            started_r <= started_nxt;
            phase_r <= phase_nxt;
            pst_r <= pst_nxt;
            dd_r <= dd_nxt;
            all_r <= all_nxt;
        end
    end
    assign status_clock_o = phase_r;
    assign processor_status_o = pst_r;
    assign debug_data_o = dd_r;
    assign status_data_bus_o = {dd_r, pst_r};
    assign status_all_ones_o = all_r;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    a_strap_fixed: assert property (strap_done |=> $stable(jtag_mode_r))
        else $error("debug select changed after capture");
    a_tdo_fall_only: assert property (disable iff (!tap_rst_n) !tck_fall |=> $stable(tdo_o))
        else $error("tdo changed without test clock fall");
    a_tdo_oe_shift: assert property (disable iff (!tap_rst_n)
        tck_fall |=> tdo_oe_o == ($past(tap.state) == ST_SH_IR || $past(tap.state) == ST_SH_DR))
        else $error("tdo enable wrong for state");
    a_ds_valid_lvl: assert property ($rose(ds_lvl_r) |-> $past(sync2_r[P_DSC], 1) && $past(sync2_r[P_DSC], 2))
        else $error("serial clock accepted without two equal samples");
    a_dso_step: assert property (!ds_rise |=> $stable(dev_serial_out_o))
        else $error("serial output moved without validated rise");
    a_brk_wait: assert property ((brk_r == BRK_PEND && !instr_done_i) |=> !halt_o)
        else $error("halt before instruction completed");
    a_bkd_irq: assert property ((brk_r == BRK_PEND && instr_done_i && breakpoint_disable_i)
        |=> debug_irq_o && !halt_o ##1 !debug_irq_o)
        else $error("disabled breakpoint did not raise interrupt");
    a_halt_pst: assert property ((halt_o && load) |=> processor_status_o == PST_HALT
        && status_data_bus_o == {DDATA_HALT, PST_HALT})
        else $error("halt not shown on status outputs");
    a_all_ones: assert property (1'b1 |-> status_all_ones_o == &processor_status_o)
        else $error("combined status is not the AND of status");
    a_sclk_idle: assert property (!started_r |-> !status_clock_o)
        else $error("status clock ran before reset status");
    a_pcd_freeze: assert property ((started_r && status_clock_disable_i) |=> $stable(status_clock_o)
        && $stable(processor_status_o))
        else $error("trace moved while disabled");
    a_sclk_mid: assert property (($rose(status_clock_o) && !status_clock_disable_i)
        |-> $stable(processor_status_o) ##1 $fell(status_clock_o))
        else $error("status clock rise not mid window");
    c_halt: cover property (brk_r == BRK_PEND ##1 halt_o);
    c_packet: cover property (pkt_rx_valid_o);
    c_tdo_drive: cover property ($rose(tdo_oe_o));
    c_sclk_run: cover property ($rose(status_clock_o) ##2 $rose(status_clock_o));
endmodule : debug_port
`default_nettype wire

// *** testbench/debug_probe.sv ***
// Probe model driving the serial debug link
`default_nettype none
module debug_probe (
    // Clock
    input wire logic mclk_i,
    // Serial link
    input wire logic dev_serial_out_i,
    output logic dev_serial_clock_o,
    output logic dev_serial_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************
    // Link timing
    // ************************************************
    // Period 12 clocks: slower than one fifth of the status clock
    localparam int HALF = 6;
    initial begin
        dev_serial_clock_o = 1'b0;
        dev_serial_in_o = 1'b1;
    end
    // Clock idles low between frames; released data shows inverse of last bit
    task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
        for (int i = 16; i >= 0; i--) begin
            dev_serial_in_o = tx[i];
            repeat (HALF) @(negedge mclk_i);
            dev_serial_clock_o = 1'b1;
            repeat (HALF) @(negedge mclk_i);
            rx[i] = dev_serial_out_i;
            dev_serial_clock_o = 1'b0;
        end
        dev_serial_in_o = ~tx[0];
    endtask : xfer
    // One-cycle spike, too short to be validated
    task automatic glitch;
        dev_serial_clock_o = 1'b1;
        @(negedge mclk_i);
        dev_serial_clock_o = 1'b0;
        repeat (HALF) @(negedge mclk_i);
    endtask : glitch
endmodule : debug_probe
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the debug, trace and test port
`default_nettype none
module testbench import dbg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************
    // Signals
    // ************************************************
    logic mclk_i = 1'b0, arst_n_i, jtag_en_i, trst_n_i, tclk_i, tms_i, tdi_i, tdo_o, tdo_oe_o, jtag_mode_o;
    logic breakpoint_request_i, breakpoint_disable_i, instr_done_i, resume_i, status_clock_disable_i;
    logic dev_serial_out_o, pkt_rx_valid_o, halt_o, debug_irq_o, status_all_ones_o, status_clock_o;
    logic [3:0] test_instr_o, core_status_i, core_data_i, processor_status_o, debug_data_o;
    logic [7:0] status_data_bus_o;
    logic [16:0] pkt_tx_data_i, pkt_rx_data_o, rx_word;
    wire logic dev_serial_clock_i, dev_serial_in_i;
    logic tdo_seen, oe_seen;
    int rx_pulses = 0, checks = 0, miscompares = 0;
    always #12.5 mclk_i = ~mclk_i;
    debug_port debug_port_i (.mclk_i, .arst_n_i, .jtag_en_i, .trst_n_i, .tclk_i, .tms_i, .tdi_i, .tdo_o,
        .tdo_oe_o, .jtag_mode_o, .test_instr_o, .dev_serial_clock_i, .dev_serial_in_i, .dev_serial_out_o,
        .pkt_tx_data_i, .pkt_rx_valid_o, .pkt_rx_data_o, .breakpoint_request_i, .breakpoint_disable_i,
        .instr_done_i, .resume_i, .core_status_i, .core_data_i, .halt_o, .debug_irq_o, .status_clock_disable_i,
        .processor_status_o, .debug_data_o, .status_data_bus_o, .status_all_ones_o, .status_clock_o);
    debug_probe debug_probe_i (.mclk_i, .dev_serial_out_i(dev_serial_out_o),
        .dev_serial_clock_o(dev_serial_clock_i), .dev_serial_in_o(dev_serial_in_i));
    always @(posedge mclk_i) begin
        if (pkt_rx_valid_o === 1'b1) begin
            rx_word <= pkt_rx_data_o;
            rx_pulses <= rx_pulses + 1;
        end
    end
    // ************************************************
    // Helpers
    // ************************************************
    task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic do_reset(input logic jen);
        arst_n_i = 1'b0;
        jtag_en_i = jen;
        repeat (4) @(negedge mclk_i);
        check("reset_instr", test_instr_o, 4'hF);
        arst_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        check("mode", jtag_mode_o, jen);
    endtask : do_reset
    // Test clock 200 ns; tdo sampled late in the low phase
    task automatic tck(input logic ms, input logic di);
        tms_i = ms;
        tdi_i = di;
        tclk_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        tdo_seen = tdo_o;
        oe_seen = tdo_oe_o;
        tclk_i = 1'b1;
        repeat (4) @(negedge mclk_i);
    endtask : tck
    task automatic toggles(input int n, output int t);
        logic p;
        t = 0;
        for (int i = 0; i < n; i++) begin
            p = status_clock_o;
            @(negedge mclk_i);
            t += int'(p !== status_clock_o);
        end
    endtask : toggles
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic test_trace;
        int t;
        core_status_i = 4'h1;
        toggles(10, t);
        check("idle_clock", t, 0);
        core_status_i = PST_C;
        repeat (3) @(negedge mclk_i);
        toggles(8, t);
        check("running_clock", t, 8);
        check("status_bus", {debug_data_o, status_data_bus_o}, 12'hAAC);
        while (status_clock_o !== 1'b0) @(negedge mclk_i);
        core_status_i = PST_D;
        @(negedge mclk_i);
        check("mid_window", {status_clock_o, processor_status_o}, {1'b1, PST_C});
        @(negedge mclk_i);
        check("new_window", {status_clock_o, processor_status_o}, {1'b0, PST_D});
        status_clock_disable_i = 1'b1;
        @(negedge mclk_i);
        core_status_i = PST_C;
        toggles(6, t);
        check("frozen", {t[3:0], processor_status_o}, {4'h0, PST_D});
        status_clock_disable_i = 1'b0;
        toggles(6, t);
        check("restart", t > 0, 1'b1);
        $display("test_trace done");
    endtask : test_trace
    task automatic test_link;
        logic [16:0] rx;
        pkt_tx_data_i = 17'h1A5C3;
        debug_probe_i.xfer(17'h0B6E9, rx);
        repeat (3) @(negedge mclk_i);
        check("rx_count", rx_pulses, 1);
        check("rx_data", rx_word, 17'h0B6E9);
        check("first_resp", rx, 17'h00000);
        pkt_tx_data_i = 17'h00000;
        debug_probe_i.glitch();
        debug_probe_i.xfer(17'h10001, rx);
        repeat (3) @(negedge mclk_i);
        check("resp", rx, 17'h1A5C3);
        check("rx_after_glitch", {rx_pulses[0], rx_word}, {1'b0, 17'h10001});
        $display("test_link done");
    endtask : test_link
    task automatic test_brk;
        int n;
        core_status_i = 4'h1;
        breakpoint_request_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        check("early_halt", halt_o, 1'b0);
        instr_done_i = 1'b1;
        @(negedge mclk_i);
        instr_done_i = 1'b0;
        @(negedge mclk_i);
        check("halt", halt_o, 1'b1);
        repeat (4) @(negedge mclk_i);
        check("halt_trace", {status_all_ones_o, status_data_bus_o}, {1'b1, 8'hFF});
        breakpoint_request_i = 1'b0;
        resume_i = 1'b1;
        @(negedge mclk_i);
        resume_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        check("resumed", {halt_o, status_all_ones_o, processor_status_o}, {2'b00, 4'h1});
        breakpoint_disable_i = 1'b1;
        breakpoint_request_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        instr_done_i = 1'b1;
        n = 0;
        repeat (12) begin
            @(negedge mclk_i);
            instr_done_i = 1'b0;
            n += int'(debug_irq_o === 1'b1);
        end
        check("irq_pulses", n, 1);
        check("no_halt", halt_o, 1'b0);
        breakpoint_request_i = 1'b0;
        $display("test_brk done");
    endtask : test_brk
    task automatic test_jtag;
        logic [3:0] sh = 4'h5;
        do_reset(1'b1);
        repeat (5) tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b0);
        check("oe_idle", oe_seen, 1'b0);
        for (int i = 0; i < 4; i++) begin
            tck(i == 3, sh[i]);
            check("ir_oe", oe_seen, 1'b1);
            check("ir_tdo", tdo_seen, IR_CAPT[i]);
        end
        tck(1'b1, 1'b0);
        check("oe_exit", oe_seen, 1'b0);
        tck(1'b0, 1'b0);
        check("instr", test_instr_o, 4'h5);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b1);
        tck(1'b1, 1'b0);
        check("dr_tdo", {oe_seen, tdo_seen}, 2'b11);
        trst_n_i = 1'b0;
        #1;
        check("trst", {tdo_oe_o, test_instr_o}, {1'b0, 4'hF});
        @(negedge mclk_i);
        trst_n_i = 1'b1;
        $display("test_jtag done");
    endtask : test_jtag
    // ************************************************
    // Sequence and verdict
    // ************************************************
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        {tclk_i, tms_i, tdi_i, breakpoint_request_i, breakpoint_disable_i} = '0;
        {instr_done_i, resume_i, status_clock_disable_i} = '0;
        trst_n_i = 1'b1;
        core_status_i = PST_RST;
        core_data_i = 4'hA;
        pkt_tx_data_i = '0;
        do_reset(1'b0);
        test_trace();
        test_link();
        test_brk();
        test_jtag();
        complete_run();
    end
    // Whole run is under 4000 cycles; allow a wide margin
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
